// ---- rtl/acs_pkg.sv ----
`default_nettype none
package acs_pkg;
  // Board clock
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Register offsets on the parallel bus
  localparam logic [5:0] CSR_OFS  = 6'h02;
  localparam logic [5:0] DATA_OFS = 6'h04;

  // Control and status word field positions
  localparam int unsigned BIT_READY = 15;
  localparam int unsigned BIT_LAMP  = 14;
  localparam int unsigned BIT_PEND  = 13;
  localparam int unsigned BIT_FMT   = 12;
  localparam int unsigned BIT_FAST  = 8;
  localparam int unsigned BIT_ACQ   = 6;
  localparam int unsigned BIT_CLR   = 5;
  localparam int unsigned SEL_MSB   = 3;

  // Values after reset
  localparam logic [15:0] CSR_RESET  = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // Input settling time, rounded up to whole cycles
  localparam int unsigned SETTLE_NS  = 8000;
  localparam logic [15:0] SETTLE_CYC =
    16'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Output refresh intervals (nominal)
  localparam int unsigned REFRESH_SLOW_NS  = 1700000;
  localparam int unsigned REFRESH_FAST_NS  = 400000;
  localparam int unsigned REFRESH_SLOW_CYC = REFRESH_SLOW_NS / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_FAST_CYC = REFRESH_FAST_NS / CLK_PERIOD_NS;

  // Host bus request
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } acs_bus_req_t;

  // Converter answer
  typedef struct packed {
    logic        done;
    logic [11:0] code;
  } acs_adc_res_t;
endpackage
`default_nettype wire

// ---- rtl/acs_refresh.sv ----
`default_nettype none
module acs_refresh
  import acs_pkg::*;
#(
  parameter int unsigned SLOW_CYC = REFRESH_SLOW_CYC,
  parameter int unsigned FAST_CYC = REFRESH_FAST_CYC
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Control
  input  wire logic fast,
  // Refresh strobe
  output logic      tick
);
  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic [19:0] last;

  // Interval end follows the rate bit live; a rate change takes effect at once
  always_comb begin
    last    = fast ? 20'(FAST_CYC - 1) : 20'(SLOW_CYC - 1);
    tick    = (cnt_r >= last);
    cnt_nxt = tick ? 20'h0_0000 : cnt_r + 20'h0_0001;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 20'h0_0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/acs_ctrl.sv ----
// Contract
// - Refresh interval 1.7 ms, or 0.4 ms
// - Begin-acquisition write starts input settling
// - Timing clear bit abandons acquisition and conversion
// - Bits 3..0 select the input channel
// - Control bits read back; 15,13,6 are live
// - Sample-ready set when result is stored
// - Reading sample register clears sample-ready
// - Conversion-trigger write sets conversion-pending
// - Pending clears when the new result lands
// - Settling never finishes without pending conversion
// - Busy settling flags high, ignores begin writes
// - Begin write accepted whenever settling idle and stored clear bit low
// - Trigger ignored while unread result; settling held
// - Bit 12 picks offset binary or two's complement
// - Result right-justified, upper bits zero or sign
// - Begin and trigger bits act only when written
`default_nettype none
module acs_ctrl
  import acs_pkg::*;
#(
  parameter int unsigned SLOW_CYC = REFRESH_SLOW_CYC,
  parameter int unsigned FAST_CYC = REFRESH_FAST_CYC
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Host bus
  input  wire acs_bus_req_t bus_req,
  output logic [15:0]       bus_rdata,
  output logic              bus_ack,
  // Converter
  input  wire acs_adc_res_t adc_res,
  output logic [3:0]        adc_channel,
  output logic              adc_settling,
  output logic              adc_start,
  // Analog output refresh
  output logic              refresh_tick
);
  typedef enum logic [1:0] {
    ACS_IDLE   = 2'b01,
    ACS_SETTLE = 2'b10
  } acs_state_t;

  // Register state
  acs_state_t  state_r, state_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic        pend_r, pend_nxt;
  logic        ready_r, ready_nxt;
  logic        conv_r, conv_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        ack_r, ack_nxt;

  // Decoded bus events
  logic        wr_csr;
  logic        rd_data;
  logic        clr;
  logic        acq;
  logic        settle_done;
  logic        finish;
  logic [15:0] status;

  // Raw code is offset binary; flip the MSB and extend for two's complement
  function automatic logic [15:0] acs_format(input logic [11:0] code, input logic offs);
    logic [11:0] c;
    c = offs ? code : {~code[11], code[10:0]};
    return offs ? {4'h0, c} : {{4{c[11]}}, c};
  endfunction

  // Status view: control bits mirrored, three live flags substituted
  function automatic logic [15:0] acs_view(input logic [15:0] c, input logic rdy,
                                           input logic pnd, input logic aq);
    logic [15:0] v;
    v           = c;
    v[BIT_READY] = rdy;
    v[BIT_PEND]  = pnd;
    v[BIT_ACQ]   = aq;
    return v;
  endfunction

  // Bus decode and sequencing conditions
  always_comb begin
    wr_csr      = bus_req.sel && bus_req.wr && (bus_req.addr == CSR_OFS);
    rd_data     = bus_req.sel && !bus_req.wr && (bus_req.addr == DATA_OFS);
    clr         = ctrl_r[BIT_CLR];
    acq         = (state_r == ACS_SETTLE);
    settle_done = (cnt_r >= SETTLE_CYC - 16'h0001);
    // Holding settling until the old sample is read avoids overwriting it
    finish      = acq && settle_done && pend_r && !ready_r && !conv_r;
    status      = acs_view(ctrl_r, ready_r, pend_r, acq);
  end

  // Control word; strobe bits are not stored so they never re-fire
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_csr) begin
      ctrl_nxt           = bus_req.wdata;
      ctrl_nxt[BIT_READY] = 1'b0;
      ctrl_nxt[BIT_PEND]  = 1'b0;
      ctrl_nxt[BIT_ACQ]   = 1'b0;
    end
  end

  // Settling sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ACS_IDLE: begin
        cnt_nxt = 16'h0000;
        if (wr_csr && bus_req.wdata[BIT_ACQ] && !clr) begin
          state_nxt = ACS_SETTLE;
        end
      end
      ACS_SETTLE: begin
        // Further begin writes fall through here unused
        if (!settle_done) begin
          cnt_nxt = cnt_r + 16'h0001;
        end
        if (finish) begin
          state_nxt = ACS_IDLE;
        end
      end
      default: begin
        state_nxt = ACS_IDLE;
        cnt_nxt   = 16'h0000;
      end
    endcase
    if (clr) begin
      state_nxt = ACS_IDLE;
      cnt_nxt   = 16'h0000;
    end
  end

  // Conversion flags and sample register
  always_comb begin
    pend_nxt  = pend_r;
    ready_nxt = ready_r;
    conv_nxt  = conv_r;
    data_nxt  = data_r;
    if (finish) begin
      conv_nxt = 1'b1;
    end
    if (rd_data) begin
      ready_nxt = 1'b0;
    end
    // A result landing in the read cycle wins over the clear
    if (conv_r && adc_res.done) begin
      conv_nxt  = 1'b0;
      pend_nxt  = 1'b0;
      ready_nxt = 1'b1;
      data_nxt  = acs_format(adc_res.code, ctrl_r[BIT_FMT]);
    end
    // Host trigger wins over the completion clear, so no trigger is lost
    if (wr_csr && bus_req.wdata[BIT_PEND] && !ready_r) begin
      pend_nxt = 1'b1;
    end
    if (clr) begin
      pend_nxt  = 1'b0;
      ready_nxt = 1'b0;
      conv_nxt  = 1'b0;
    end
  end

  // Registered read data; unmapped offsets read zero
  always_comb begin
    ack_nxt   = bus_req.sel;
    rdata_nxt = 16'h0000;
    if (bus_req.sel && !bus_req.wr) begin
      if (bus_req.addr == CSR_OFS) begin
        rdata_nxt = status;
      end else if (bus_req.addr == DATA_OFS) begin
        rdata_nxt = data_r;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= ACS_IDLE;
      ctrl_r  <= CSR_RESET;
      data_r  <= DATA_RESET;
      cnt_r   <= 16'h0000;
      pend_r  <= 1'b0;
      ready_r <= 1'b0;
      conv_r  <= 1'b0;
      rdata_r <= 16'h0000;
      ack_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
      data_r  <= data_nxt;
      cnt_r   <= cnt_nxt;
      pend_r  <= pend_nxt;
      ready_r <= ready_nxt;
      conv_r  <= conv_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  // Refresh timer
  acs_refresh #(
    .SLOW_CYC (SLOW_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_refresh (
    .clock (clock),
    .nrst  (nrst),
    .fast  (ctrl_r[BIT_FAST]),
    .tick  (refresh_tick)
  );

  // Outputs
  assign bus_rdata    = rdata_r;
  assign bus_ack      = ack_r;
  assign adc_channel  = ctrl_r[SEL_MSB:0];
  assign adc_settling = acq;
  assign adc_start    = finish;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  acq_start_a: assert property (
    wr_csr && bus_req.wdata[BIT_ACQ] && !acq && !clr |=> acq)
    else $error("begin-acquisition write not taken");

  acq_hold_a: assert property (
    acq && !clr && !finish |=> acq && status[BIT_ACQ])
    else $error("settling dropped early");

  settle_wait_a: assert property (
    acq && !pend_r |-> !adc_start)
    else $error("settling finished without pending conversion");

  clr_flags_a: assert property (
    clr |=> !acq && !pend_r && !ready_r && !conv_r)
    else $error("timing clear left a flag set");

  pend_set_a: assert property (
    wr_csr && bus_req.wdata[BIT_PEND] && !ready_r && !clr |=> pend_r)
    else $error("trigger did not set pending");

  pend_block_a: assert property (
    wr_csr && bus_req.wdata[BIT_PEND] && ready_r && !pend_r |=> !pend_r)
    else $error("trigger accepted over unread result");

  result_land_a: assert property (
    conv_r && adc_res.done && !clr |=> ready_r
      && (!pend_r || ($past(wr_csr) && $past(bus_req.wdata[BIT_PEND])))
      && data_r == acs_format($past(adc_res.code), $past(ctrl_r[BIT_FMT])))
    else $error("result did not land");

  ready_clear_a: assert property (
    rd_data && !(conv_r && adc_res.done) |=> !ready_r)
    else $error("sample read did not clear ready");

  ctrl_readback_a: assert property (
    wr_csr |=> status[BIT_FMT:7] == $past(bus_req.wdata[BIT_FMT:7])
      && status[BIT_CLR:0] == $past(bus_req.wdata[BIT_CLR:0]))
    else $error("control bits do not read back");
endmodule
`default_nettype wire

// ---- testbench/acs_conv_model.sv ----
`default_nettype none
module acs_conv_model
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Controls from the block and the bench
  input  wire logic        adc_start,
  input  wire logic [3:0]  lat,
  input  wire logic [11:0] code_in,
  // Result to the block
  output var acs_adc_res_t adc_res
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;

  // Code toggles outside done so a stale value is never mistaken for a result
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r   <= 4'h0;
      adc_res <= '0;
    end else begin
      adc_res.done <= 1'b0;
      adc_res.code <= ~adc_res.code;
      if (adc_start) begin
        cnt_r <= lat;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          adc_res <= '{done: 1'b1, code: code_in};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SLOW = 20;
  localparam int unsigned FAST = 8;
  logic         clock, nrst, adc_start, adc_settling, bus_ack, refresh_tick;
  acs_bus_req_t bus_req;
  acs_adc_res_t adc_res;
  logic [15:0]  bus_rdata, w, r;
  logic [3:0]   adc_channel, lat;
  logic [11:0]  code_in;
  int           miscompares, checks_done;

  acs_ctrl #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) uut (.clock(clock), .nrst(nrst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .adc_res(adc_res),
    .adc_channel(adc_channel), .adc_settling(adc_settling), .adc_start(adc_start),
    .refresh_tick(refresh_tick));
  acs_conv_model conv (.clock(clock), .nrst(nrst), .adc_start(adc_start), .lat(lat),
    .code_in(code_in), .adc_res(adc_res));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // One access; answer is sampled just after the edge that raises ack
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clock);
    bus_req <= '{sel: 1'b1, wr: wr, addr: a, wdata: d};
    @(posedge clock);
    bus_req.sel <= 1'b0;
    #1;
    q = bus_rdata;
    chk("ack", 16'h0001, {15'h0, bus_ack});
  endtask

  task automatic wait_start(input int n, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++) begin
      @(negedge clock);
      seen = (adc_start === 1'b1);
    end
  endtask

  task automatic wait_ready(output logic [15:0] q);
    int n;
    n = 0;
    do begin
      bus(1'b0, CSR_OFS, 16'h0, q);
      n++;
    end while (q[BIT_READY] !== 1'b1 && n < 500);
  endtask

  // Raw code is offset binary; two's complement flips the MSB and extends it
  function automatic logic [15:0] exp_data(input logic [11:0] c, input logic fmt);
    return fmt ? {4'h0, c} : {{5{~c[11]}}, c[10:0]};
  endfunction

  task automatic refresh(input logic fast, input int exp);
    int n;
    bus(1'b1, CSR_OFS, {7'h0, fast, 8'h00}, r);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (refresh_tick !== 1'b1 && n < 100);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (refresh_tick !== 1'b1 && n < 100);
    chk("refresh_gap", 16'(exp), 16'(n));
  endtask

  task automatic convert(input logic fmt);
    logic [11:0] c;
    logic        seen;
    c = 12'($urandom);
    w = {3'b011, fmt, 8'($urandom) & 8'hFD, 4'($urandom)} | 16'h0040;
    @(posedge clock);
    code_in <= c;
    lat     <= 4'($urandom_range(1, 9));
    bus(1'b1, CSR_OFS, w, r);
    bus(1'b0, CSR_OFS, 16'h0, r);
    chk("status_busy", w, r);
    chk("channel", {12'h0, w[3:0]}, {12'h0, adc_channel});
    chk("settling", 16'h0001, {15'h0, adc_settling});
    wait_start(900, seen);
    chk("conv_start", 16'h0001, {15'h0, seen});
    wait_ready(r);
    chk("status_ready", (w & 16'hDFBF) | 16'h8000, r);
    chk("settled", 16'h0000, {15'h0, adc_settling});
    bus(1'b0, DATA_OFS, 16'h0, r);
    chk("sample", exp_data(c, fmt), r);
    bus(1'b0, CSR_OFS, 16'h0, r);
    chk("ready_clear", 16'h0, {15'h0, r[BIT_READY]});
    $display("test convert fmt %0d done", fmt);
  endtask

  initial begin
    repeat (15000) @(posedge clock);
    miscompares++;
    finish_test();
  end

  initial begin
    logic seen;
    nrst    = 1'b0;
    bus_req = '0;
    code_in = 12'h000;
    lat     = 4'h1;
    void'($urandom(55670));
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    bus(1'b0, CSR_OFS, 16'h0, r);
    chk("csr_reset", CSR_RESET, r);
    bus(1'b0, DATA_OFS, 16'h0, r);
    chk("data_reset", DATA_RESET, r);
    $display("test reset done");
    // Stored bits read back; strobes, clear and flags kept out
    for (int i = 0; i < 6; i++) begin
      w = 16'($urandom) & 16'h5F9F;
      bus(1'b1, CSR_OFS, w, r);
      bus(1'b1, 6'h06, ~w, r);
      bus(1'b0, CSR_OFS, 16'h0, r);
      chk("readback", w, r);
      chk("channel", {12'h0, w[3:0]}, {12'h0, adc_channel});
      bus(1'b0, 6'h06, 16'h0, r);
      chk("unmapped", 16'h0, r);
    end
    $display("test readback done");
    refresh(1'b0, SLOW);
    refresh(1'b1, FAST);
    $display("test refresh done");
    convert(1'b1);
    convert(1'b0);
    // Unread result blocks a new trigger and holds settling
    bus(1'b1, CSR_OFS, 16'h3040, r);
    wait_ready(r);
    bus(1'b1, CSR_OFS, 16'h3040, r);
    bus(1'b0, CSR_OFS, 16'h0, r);
    chk("trig_ignored", 16'h9040, r);
    wait_start(900, seen);
    chk("held", 16'h0, {15'h0, seen});
    bus(1'b0, DATA_OFS, 16'h0, r);
    wait_start(900, seen);
    chk("no_pending", 16'h0, {15'h0, seen});
    bus(1'b0, CSR_OFS, 16'h0, r);
    chk("still_busy", 16'h1040, r);
    bus(1'b1, CSR_OFS, 16'h0020, r);
    bus(1'b0, CSR_OFS, 16'h0, r);
    chk("cleared", 16'h0020, r);
    bus(1'b1, CSR_OFS, 16'h0000, r);
    bus(1'b1, CSR_OFS, 16'h0040, r);
    bus(1'b0, CSR_OFS, 16'h0, r);
    chk("restart", 16'h0040, r);
    $display("test hold and clear done");
    finish_test();
  end
endmodule
`default_nettype wire
